// ### design/rsps_top.sv
// Reset-time strap capture and shared-pin peripheral selection with register access.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rsps_map.svh"
module rsps_top
   import rsps_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Strap pins.
   input  wire logic        pci_select_strap,
   input  wire logic        mac_select_strap,
   input  wire logic        host_width_strap,
   input  wire logic        autoinit_strap_pin,
   input  wire logic        endian_strap,
   input  wire logic        pci_speed_strap,
   input  wire logic        reserved_low_strap,
   input  wire logic [3:0]  ext_addr_straps,
   // Avalon-MM slave.
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Upper general-purpose pins.
   input  wire logic [6:0]  upper_gpio_i,
   output logic [6:0]       upper_gpio_o,
   output logic [6:0]       upper_gpio_oe,
   output logic             upper_gpio_avail,
   // Peripheral selection.
   output logic             host_port_en,
   output logic             host_port_32bit,
   output logic             host_low_to_host,
   output logic             host_high_to_host,
   output logic             host_high_to_eth,
   output logic             eth_en,
   output logic             pci_en,
   output logic             pci_only_pins_en,
   output logic             eeprom_autoinit_en,
   output logic             pci_defaults_en,
   output logic             pci_33mhz,
   // Device configuration.
   output logic             big_endian,
   output logic [1:0]       boot_mode,
   output logic             boot_from_host,
   output logic             boot_from_pci,
   output logic [1:0]       mem_clock_sel,
   output logic             config_invalid
);

   rsps_strap_if cap_if ();

   rsps_state_t  state_reg;
   rsps_state_t  state_next;

   // ---------------------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------------------
   rsps_latch u_latch (
      .clk                (clk),
      .arst_n             (arst_n),
      .pci_select_strap   (pci_select_strap),
      .mac_select_strap   (mac_select_strap),
      .host_width_strap   (host_width_strap),
      .autoinit_strap_pin (autoinit_strap_pin),
      .endian_strap       (endian_strap),
      .pci_speed_strap    (pci_speed_strap),
      .reserved_low_strap (reserved_low_strap),
      .ext_addr_straps    (ext_addr_straps),
      .cap                (cap_if.latch)
   );

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   // Merge a write into a 7-bit register; only byte lane 0 carries the field.
   function automatic logic [6:0] rsps_merge(input logic [6:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be);
      rsps_merge = be[0] ? wdata[6:0] : old_val;
   endfunction : rsps_merge

   // Status word built from the captured straps.
   function automatic logic [31:0] rsps_status(input rsps_straps_t s,
                                               input logic cap,
                                               input logic inval);
      logic [31:0] w;
      w                                            = 32'h0000_0000;
      w[`RSPS_ST_PCI_SEL]                          = s.pci_select;
      w[`RSPS_ST_MAC_SEL]                          = s.mac_select;
      w[`RSPS_ST_HOST_WIDTH]                       = s.host_width;
      w[`RSPS_ST_AUTOINIT]                         = s.autoinit;
      w[`RSPS_ST_ENDIAN]                           = s.endian;
      w[`RSPS_ST_PCI_SPEED]                        = s.pci_speed;
      w[`RSPS_ST_RSVD_LOW]                         = s.reserved_low;
      w[`RSPS_ST_EXT_ADDR_HI:`RSPS_ST_EXT_ADDR_LO] = s.ext_addr;
      w[`RSPS_ST_INVALID]                          = inval;
      w[`RSPS_ST_CAPTURED]                         = cap;
      rsps_status = w;
   endfunction : rsps_status

   // ---------------------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------------------
   // Nothing is enabled until the straps have been captured, so the shared
   // pins stay undriven until the second rising edge after reset release.
   always_comb begin
      rsps_straps_t s;
      logic         v;
      logic         pci;
      logic         req;
      logic [31:0]  rd;
      rd         = 32'h0000_0000;
      s          = cap_if.straps;
      v          = cap_if.captured;
      pci        = v & s.pci_select;
      req        = avs_read | avs_write;
      state_next = state_reg;

      // Shared-pin ownership.  PCI wins over all other functions.
      state_next.pci_en            = pci;
      state_next.pci_only_pins_en  = pci;
      state_next.host_port_en      = v & ~s.pci_select
                                     & ~(s.host_width & s.mac_select);
      state_next.host_low_to_host  = v & ~s.pci_select
                                     & ~(s.host_width & s.mac_select);
      state_next.host_port_32bit   = v & ~s.pci_select & s.host_width
                                     & ~s.mac_select;
      state_next.host_high_to_host = v & ~s.pci_select & s.host_width
                                     & ~s.mac_select;
      state_next.host_high_to_eth  = v & ~s.pci_select & s.mac_select;
      state_next.eth_en            = v & ~s.pci_select & s.mac_select;
      state_next.upper_gpio_avail  = v & ~s.pci_select;

      // PCI initialisation source and speed matter only with PCI owning pins.
      state_next.eeprom_autoinit_en = pci & s.autoinit;
      state_next.pci_defaults_en    = pci & ~s.autoinit;
      state_next.pci_33mhz          = pci & s.pci_speed;

      // Upper GPIO drive: enable and direction both set, and PCI absent.
      state_next.upper_gpio_o  = state_reg.gpio_out;
      state_next.upper_gpio_oe = (v & ~s.pci_select) ? 
                                 (state_reg.gpio_en & state_reg.gpio_dir) : 7'h00;

      // Device configuration decoded from the captured straps.
      state_next.big_endian     = v & ~s.endian;
      state_next.boot_mode      = rsps_boot_t'(s.ext_addr[3:2]);
      state_next.boot_from_host = v & ~s.pci_select
                                  & (s.ext_addr[3:2] == `RSPS_BOOT_HOST_PCI);
      state_next.boot_from_pci  = pci
                                  & (s.ext_addr[3:2] == `RSPS_BOOT_HOST_PCI);
      state_next.mem_clock_sel  = rsps_mclk_t'(s.ext_addr[1:0]);
      // A high reserved-low strap is the board breaking its side; flag it.
      state_next.config_invalid = v & (s.reserved_low
                                  | (s.ext_addr[3:2] == `RSPS_BOOT_RSVD)
                                  | (s.ext_addr[1:0] == `RSPS_MCLK_RSVD)
                                  | (s.pci_select & s.mac_select));

      // Bus slave: waitrequest drops for one cycle, on the first edge that samples the request
      // is seen.  Writes commit on the edge where the master sees it low.
      state_next.waitrequest = ~(req & state_reg.waitrequest);
      if (avs_write & ~state_reg.waitrequest) begin
         unique case (avs_address)
            `RSPS_OFS_GPIO_EN: begin
               state_next.gpio_en = rsps_merge(state_reg.gpio_en, avs_writedata,
                                               avs_byteenable);
            end
            `RSPS_OFS_GPIO_DIR: begin
               state_next.gpio_dir = rsps_merge(state_reg.gpio_dir, avs_writedata,
                                                avs_byteenable);
            end
            `RSPS_OFS_GPIO_OUT: begin
               state_next.gpio_out = rsps_merge(state_reg.gpio_out, avs_writedata,
                                                avs_byteenable);
            end
            default: begin
            end
         endcase
      end

      // Read data is prepared on the edge that lowers waitrequest.
      unique case (avs_address)
         `RSPS_OFS_STATUS:   rd = rsps_status(s, v, state_next.config_invalid);
         `RSPS_OFS_GPIO_EN:  rd = {25'h0000000, state_reg.gpio_en};
         `RSPS_OFS_GPIO_DIR: rd = {25'h0000000, state_reg.gpio_dir};
         `RSPS_OFS_GPIO_OUT: rd = {25'h0000000, state_reg.gpio_out};
         `RSPS_OFS_GPIO_IN:  rd = {25'h0000000, upper_gpio_i};
         default:            rd = 32'h0000_0000; // Unmapped reads return zero.
      endcase
      if (avs_read & state_reg.waitrequest) begin
         state_next.readdata = rd;
      end
   end

   // ---------------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg             <= '0;
         state_reg.waitrequest <= 1'b1;
         state_reg.readdata    <= `RSPS_RDATA_RST;
         state_reg.gpio_en     <= `RSPS_GPIO_RST;
         state_reg.gpio_dir    <= `RSPS_GPIO_RST;
         state_reg.gpio_out    <= `RSPS_GPIO_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------------------
   // Outputs, all taken straight from the state register
   // ---------------------------------------------------------------------------
   assign avs_readdata       = state_reg.readdata;
   assign avs_waitrequest    = state_reg.waitrequest;
   assign upper_gpio_o       = state_reg.upper_gpio_o;
   assign upper_gpio_oe      = state_reg.upper_gpio_oe;
   assign upper_gpio_avail   = state_reg.upper_gpio_avail;
   assign host_port_en       = state_reg.host_port_en;
   assign host_port_32bit    = state_reg.host_port_32bit;
   assign host_low_to_host   = state_reg.host_low_to_host;
   assign host_high_to_host  = state_reg.host_high_to_host;
   assign host_high_to_eth   = state_reg.host_high_to_eth;
   assign eth_en             = state_reg.eth_en;
   assign pci_en             = state_reg.pci_en;
   assign pci_only_pins_en   = state_reg.pci_only_pins_en;
   assign eeprom_autoinit_en = state_reg.eeprom_autoinit_en;
   assign pci_defaults_en    = state_reg.pci_defaults_en;
   assign pci_33mhz          = state_reg.pci_33mhz;
   assign big_endian         = state_reg.big_endian;
   assign boot_mode          = state_reg.boot_mode;
   assign boot_from_host     = state_reg.boot_from_host;
   assign boot_from_pci      = state_reg.boot_from_pci;
   assign mem_clock_sel      = state_reg.mem_clock_sel;
   assign config_invalid     = state_reg.config_invalid;

endmodule : rsps_top

// ### include/rsps_map.svh
// Register offsets, field positions and reset values of the strap selection block.
`ifndef RSPS_MAP_SVH
`define RSPS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RSPS_OFS_STATUS      5'h00
`define RSPS_OFS_GPIO_EN     5'h04
`define RSPS_OFS_GPIO_DIR    5'h08
`define RSPS_OFS_GPIO_OUT    5'h0c
`define RSPS_OFS_GPIO_IN     5'h10

// ----------------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------------
`define RSPS_ST_PCI_SEL      0
`define RSPS_ST_MAC_SEL      1
`define RSPS_ST_HOST_WIDTH   2
`define RSPS_ST_AUTOINIT     3
`define RSPS_ST_ENDIAN       4
`define RSPS_ST_PCI_SPEED    5
`define RSPS_ST_RSVD_LOW     6
`define RSPS_ST_EXT_ADDR_LO  8
`define RSPS_ST_EXT_ADDR_HI  11
`define RSPS_ST_INVALID      12
`define RSPS_ST_CAPTURED     13

// ----------------------------------------------------------------------------
// Reset values and decode codes
// ----------------------------------------------------------------------------
`define RSPS_GPIO_RST        7'h00
`define RSPS_RDATA_RST       32'h0000_0000
`define RSPS_BOOT_RSVD       2'h2
`define RSPS_BOOT_HOST_PCI   2'h1
`define RSPS_MCLK_RSVD       2'h3

`endif

// ### include/rsps_pkg.sv
// Types shared by the strap selection modules.
package rsps_pkg;

   // Captured strap levels.
   typedef struct packed {
      logic       pci_select;
      logic       mac_select;
      logic       host_width;
      logic       autoinit;
      logic       endian;
      logic       pci_speed;
      logic       reserved_low;
      logic [3:0] ext_addr;
   } rsps_straps_t;

   // Boot mode encoding held in the upper two external-address straps.
   typedef enum logic [1:0] {
      RSPS_BOOT_NONE     = 2'h0,
      RSPS_BOOT_HOST_PCI = 2'h1,
      RSPS_BOOT_RESERVED = 2'h2,
      RSPS_BOOT_EXT_MEM  = 2'h3
   } rsps_boot_t;

   // External memory clock source held in the lower two external-address straps.
   typedef enum logic [1:0] {
      RSPS_MCLK_EXT_INPUT = 2'h0,
      RSPS_MCLK_CPU_DIV4  = 2'h1,
      RSPS_MCLK_CPU_DIV6  = 2'h2,
      RSPS_MCLK_RESERVED  = 2'h3
   } rsps_mclk_t;

   // State of the strap capture module.
   typedef struct packed {
      logic         captured;
      rsps_straps_t straps;
   } rsps_latch_state_t;

   // State of the top module: every output and register lives here.
   typedef struct packed {
      logic         waitrequest;
      logic [31:0]  readdata;
      logic [6:0]   gpio_en;
      logic [6:0]   gpio_dir;
      logic [6:0]   gpio_out;
      logic         host_port_en;
      logic         host_port_32bit;
      logic         host_low_to_host;
      logic         host_high_to_host;
      logic         host_high_to_eth;
      logic         eth_en;
      logic         pci_en;
      logic         pci_only_pins_en;
      logic         eeprom_autoinit_en;
      logic         pci_defaults_en;
      logic         pci_33mhz;
      logic         upper_gpio_avail;
      logic [6:0]   upper_gpio_o;
      logic [6:0]   upper_gpio_oe;
      logic         big_endian;
      rsps_boot_t   boot_mode;
      logic         boot_from_host;
      logic         boot_from_pci;
      rsps_mclk_t   mem_clock_sel;
      logic         config_invalid;
   } rsps_state_t;

endpackage : rsps_pkg

// ### include/rsps_strap_if.sv
// Interface that carries the captured strap levels from the capture module.
`timescale 1ns/1ps
interface rsps_strap_if;
   import rsps_pkg::*;

   rsps_straps_t straps;
   logic         captured;

   modport latch (output straps, output captured);
   modport user  (input straps, input captured);
endinterface : rsps_strap_if

// ### design/rsps_latch.sv
// Strap capture module: samples the board straps once after reset release.
`timescale 1ns/1ps
module rsps_latch
   import rsps_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       pci_select_strap,
   input  wire logic       mac_select_strap,
   input  wire logic       host_width_strap,
   input  wire logic       autoinit_strap_pin,
   input  wire logic       endian_strap,
   input  wire logic       pci_speed_strap,
   input  wire logic       reserved_low_strap,
   input  wire logic [3:0] ext_addr_straps,
   rsps_strap_if.latch     cap
);

   rsps_latch_state_t state_reg;
   rsps_latch_state_t state_next;

   // ---------------------------------------------------------------------------
   // Capture
   // ---------------------------------------------------------------------------
   // The asynchronous reset may only load constants, so the pins are taken at
   // the first edge after release, while the board resistors still set them.
   always_comb begin
      state_next = state_reg;
      if (!state_reg.captured) begin
         state_next.captured            = 1'b1;
         state_next.straps.pci_select   = pci_select_strap;
         state_next.straps.mac_select   = mac_select_strap;
         state_next.straps.host_width   = host_width_strap;
         state_next.straps.autoinit     = autoinit_strap_pin;
         state_next.straps.endian       = endian_strap;
         state_next.straps.pci_speed    = pci_speed_strap;
         state_next.straps.reserved_low = reserved_low_strap;
         state_next.straps.ext_addr     = ext_addr_straps;
      end
      // Once captured the values are frozen until the next reset.
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cap.straps   = state_reg.straps;
   assign cap.captured = state_reg.captured;

endmodule : rsps_latch

// ### tb/rsps_props.sv
// Port-level assertions for the strap selection block.
`timescale 1ns/1ps
module rsps_props (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic [6:0] upper_gpio_oe,
   input wire logic       upper_gpio_avail,
   input wire logic       host_port_en,
   input wire logic       host_port_32bit,
   input wire logic       host_low_to_host,
   input wire logic       host_high_to_host,
   input wire logic       host_high_to_eth,
   input wire logic       eth_en,
   input wire logic       pci_en,
   input wire logic       pci_only_pins_en,
   input wire logic       eeprom_autoinit_en,
   input wire logic       pci_defaults_en,
   input wire logic       pci_33mhz,
   input wire logic       big_endian,
   input wire logic [1:0] boot_mode,
   input wire logic       boot_from_host,
   input wire logic       boot_from_pci,
   input wire logic [1:0] mem_clock_sel,
   input wire logic       config_invalid
);
   // ---------------------------------------------------------------
   // Selection and bus checks
   // ---------------------------------------------------------------
   // All checks share the one clock; reset silences them all.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_PCI_OWNS: assert property (pci_en |-> !host_port_en && !eth_en
      && !upper_gpio_avail && upper_gpio_oe == 7'h00) else $error("pci shares pins");
   AST_HOST_OWNS: assert property (upper_gpio_avail |-> !pci_en && !pci_only_pins_en
      && (host_port_en || eth_en)) else $error("host side lost its pins");
   AST_AUTOINIT: assert property (eeprom_autoinit_en || pci_defaults_en |-> pci_en
      && (eeprom_autoinit_en != pci_defaults_en)) else $error("pci init source wrong");
   AST_SPEED: assert property (pci_33mhz |-> pci_en)
      else $error("slow pci without pci");
   AST_BOOT_SRC: assert property (boot_from_pci || boot_from_host |-> boot_mode == 2'h1
      && boot_from_pci == pci_en) else $error("boot source wrong");
   AST_ETH_UPPER: assert property (host_high_to_eth |-> eth_en && !host_high_to_host
      && !host_port_32bit) else $error("upper lanes doubly owned");
   AST_WIDE_HOST: assert property (host_port_32bit |-> host_port_en
      && host_low_to_host && host_high_to_host) else $error("wide host lanes off");
   AST_INVALID: assert property (mem_clock_sel == 2'h3 || boot_mode == 2'h2
      |-> config_invalid) else $error("reserved code not flagged");
   AST_HOLD: assert property (pci_en || upper_gpio_avail |=> $stable({pci_en,
      host_port_en, eth_en, big_endian, boot_mode, mem_clock_sel}))
      else $error("selection moved");
   AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait not one cycle");
endmodule : rsps_props

bind rsps_top rsps_props i_props (.clk, .arst_n, .avs_read, .avs_write, .avs_waitrequest,
   .upper_gpio_oe, .upper_gpio_avail, .host_port_en, .host_port_32bit, .host_low_to_host,
   .host_high_to_host, .host_high_to_eth, .eth_en, .pci_en, .pci_only_pins_en,
   .eeprom_autoinit_en, .pci_defaults_en, .pci_33mhz, .big_endian, .boot_mode,
   .boot_from_host, .boot_from_pci, .mem_clock_sel, .config_invalid);

// ### tb/rsps_board.sv
// Board strap resistor model facing the strap selection block.
`timescale 1ns/1ps
module rsps_board (
   input  wire logic [10:0] cfg,
   output logic      [10:0] strap
);
   // ---------------------------------------------------------------
   // Fitted resistors
   // ---------------------------------------------------------------
   // Resistors give steady levels, so every strap is set for the whole reset.
   // The reserved-low strap is high during reset only when the bench fits a faulty board.
   assign strap = cfg;
endmodule : rsps_board

// ### tb/reset_strap_peripheral_select_test.sv
// Self-checking bench for the strap selection block.
`timescale 1ns/1ps
`include "rsps_map.svh"
module reset_strap_peripheral_select_test;
   logic        clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [3:0]  avs_byteenable = 4'hf, x;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [6:0]  upper_gpio_i = 7'h33, upper_gpio_o, upper_gpio_oe;
   logic [10:0] cfg = 11'h000, strap, c;
   logic [1:0]  boot_mode, mem_clock_sel;
   logic [19:0] exp_v, got_v;
   logic        avs_waitrequest, upper_gpio_avail, host_port_en, host_port_32bit, eth_en;
   logic        host_low_to_host, host_high_to_host, host_high_to_eth, pci_en, pci_33mhz;
   logic        pci_only_pins_en, eeprom_autoinit_en, pci_defaults_en, big_endian;
   logic        boot_from_host, boot_from_pci, config_invalid, p, m, w, a, e, s, r, he, h32;
   int          n_fail = 0, num_checks = 0;

   // ---------------------------------------------------------------
   // Board, design and clock
   // ---------------------------------------------------------------
   rsps_board i_board (.cfg(cfg), .strap(strap));
   rsps_top i_dut (.clk, .arst_n, .pci_select_strap(strap[4]), .mac_select_strap(strap[5]),
      .host_width_strap(strap[6]), .autoinit_strap_pin(strap[7]), .endian_strap(strap[8]),
      .pci_speed_strap(strap[9]), .reserved_low_strap(strap[10]), .ext_addr_straps(strap[3:0]),
      .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .upper_gpio_i, .upper_gpio_o, .upper_gpio_oe, .upper_gpio_avail,
      .host_port_en, .host_port_32bit, .host_low_to_host, .host_high_to_host,
      .host_high_to_eth, .eth_en, .pci_en, .pci_only_pins_en, .eeprom_autoinit_en,
      .pci_defaults_en, .pci_33mhz, .big_endian, .boot_mode, .boot_from_host,
      .boot_from_pci, .mem_clock_sel, .config_invalid);

   // The 200 MHz clock toggles every half period.
   always #2.5 clk = ~clk;

   task automatic test_done;
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] ev, input logic [31:0] got);
      num_checks++;
      if (got !== ev) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, ev, got);
      end
   endtask : chk

   // One bus word. The request stands until waitrequest is sampled low at a rising
   // edge; read data is taken at that same edge and only then is the request dropped.
   task automatic acc(input logic wr, input logic [4:0] adr, input logic [31:0] dat);
      @(posedge clk);
      avs_address <= adr;
      avs_writedata <= dat;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : acc

   // Reset with a board setup, then flip every strap once capture is over.
   task automatic boot(input logic [10:0] bc);
      @(posedge clk);
      arst_n <= 1'b0;
      cfg <= bc;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      cfg <= ~bc;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : boot

   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done;
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      for (int i = 0; i < 17; i++) begin
         c = {i[4], i[1] ^ i[2], i[0] ^ i[3], i[2], i[1], i[0], i[3], i[1:0], i[3:2]};
         {r, s, e, a, w, m, p, x} = c;
         he = !p && !(w && m);
         h32 = !p && w && !m;
         exp_v = {p, he, h32, he, h32, !p && m, !p && m, p, p && a, p && !a, p && s, !p, !e,
            x, !p && x[3:2] == 2'h1, p && x[3:2] == 2'h1,
            r || x[3:2] == 2'h2 || x[1:0] == 2'h3 || (p && m)};
         boot(c);
         got_v = {pci_en, host_port_en, host_port_32bit, host_low_to_host, host_high_to_host,
            host_high_to_eth, eth_en, pci_only_pins_en, eeprom_autoinit_en, pci_defaults_en,
            pci_33mhz, upper_gpio_avail, big_endian, boot_mode, mem_clock_sel,
            boot_from_host, boot_from_pci, config_invalid};
         chk("select", 32'(exp_v[19:8]), 32'(got_v[19:8]));
         chk("config", 32'(exp_v[7:0]), 32'(got_v[7:0]));
         acc(1'b0, `RSPS_OFS_STATUS, 32'h0);
         chk("status", {18'h0, 1'b1, exp_v[0], x, 1'b0, r, s, e, a, w, m, p}, rd);
      end
      boot(11'h000);
      acc(1'b1, `RSPS_OFS_GPIO_EN, 32'h7f);
      acc(1'b1, `RSPS_OFS_GPIO_DIR, 32'h55);
      acc(1'b1, `RSPS_OFS_GPIO_OUT, 32'h2a);
      avs_byteenable <= 4'he;
      acc(1'b1, `RSPS_OFS_GPIO_EN, 32'h00);
      avs_byteenable <= 4'hf;
      acc(1'b1, `RSPS_OFS_STATUS, 32'hffff_ffff);
      acc(1'b0, `RSPS_OFS_GPIO_EN, 32'h0);
      chk("gpio enable", 32'h7f, rd);
      acc(1'b0, `RSPS_OFS_GPIO_DIR, 32'h0);
      chk("gpio direction", 32'h55, rd);
      acc(1'b0, `RSPS_OFS_GPIO_OUT, 32'h0);
      chk("gpio out reg", 32'h2a, rd);
      acc(1'b0, `RSPS_OFS_GPIO_IN, 32'h0);
      chk("gpio input", 32'h33, rd);
      acc(1'b0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, rd);
      acc(1'b0, `RSPS_OFS_STATUS, 32'h0);
      chk("status", 32'h2000, rd);
      repeat (2) @(negedge clk);
      chk("gpio drive", 32'h55, 32'(upper_gpio_oe));
      chk("gpio out", 32'h2a, 32'(upper_gpio_o));
      boot(11'h010);
      acc(1'b1, `RSPS_OFS_GPIO_EN, 32'h7f);
      acc(1'b1, `RSPS_OFS_GPIO_DIR, 32'h7f);
      repeat (2) @(negedge clk);
      chk("gpio drive", 32'h0, 32'(upper_gpio_oe));
      test_done;
   end
endmodule : reset_strap_peripheral_select_test
